//--- analog_section_pkg.sv
// package: constants and types for the analog section control block
package analog_section_pkg;

  // register byte offsets on the wishbone bus
  localparam logic [3:0] CONV_CTRL_OFS  = 4'h0; // converter_control_register
  localparam logic [3:0] CONV_HIGH_OFS  = 4'h4; // converter_result_high
  localparam logic [3:0] ANALOG_STS_OFS = 4'h8; // analog status / enables
  localparam logic [3:0] SYS_CTRL_OFS   = 4'hc; // analog enable, pll mode, lock select

  // converter control write fields
  localparam int TSAMP_LSB = 6;
  localparam int REF_LSB   = 4;
  localparam int CHAN_LSB  = 0;
  // converter control read fields
  localparam int DONE_BIT  = 7;
  // analog status fields
  localparam int HS_IRQ_EN_BIT = 7;
  localparam int HS_CMP_BIT    = 6;
  localparam int WAIT_CMP_BIT  = 5;
  localparam int REG_ERR_BIT   = 0;
  // system control fields
  localparam int ANA_EN_BIT    = 0;
  localparam int PLL_MODE_LSB  = 1;
  localparam int LOCK_SEL_LSB  = 4;

  // reset values
  localparam logic [7:0] CONV_CTRL_RST = 8'h00;
  localparam logic [7:0] SYS_CTRL_RST  = 8'h00;

  // sample times per sample code and extra conversion time, in converter clocks
  localparam logic [8:0] SAMPLE_CLKS [4] = '{9'd20, 9'd60, 9'd140, 9'd300};
  localparam logic [8:0] EXTRA_CLKS      = 9'd20;
  localparam logic [10:0] ADC_STEPS      = 11'd1024;

  // lock output selection codes
  localparam logic [1:0] LOCK_SEL_OVERLOAD = 2'h1;

  // cpu modes
  typedef enum logic [2:0] {
    MODE_RESET = 3'b001,
    MODE_FAST  = 3'b010,
    MODE_SLOW  = 3'b100
  } cpu_mode_t;

  // converter sequencer states
  typedef enum logic [3:0] {
    ST_IDLE   = 4'b0001,
    ST_DELAY  = 4'b0010,
    ST_SAMPLE = 4'b0100,
    ST_CONV   = 4'b1000
  } conv_state_t;

  // power enables travel together
  typedef struct packed {
    logic ref_gen_on;
    logic regulator_on;
    logic comparators_on;
    logic converter_on;
  } power_t;

  // fields of a conversion request
  typedef struct packed {
    logic [1:0] sample_time_select;
    logic [1:0] reference_select;
    logic [3:0] input_channel_select;
  } conv_req_t;

endpackage

//--- analog_section_adc_control.sv
// analog section control: power, comparators, converter sequencer, wishbone regs
//
// The placing of the registers and the Wishbone register port were decided locally.
`timescale 1ns/100ps

// Notes on behaviour
// - reference generator on in reset, fast modes; slow modes need enable or pll.
// - regulator enabled only while pll mode field is nonzero.
// - regulator overload latched in error flag; live overload selectable on lock pin.
// - wait comparator shown as flag, interrupt source and hysteresis pin.
// - comparators and converter off after reset; analog enable turns both on outside reset cpu mode.
// - half-supply comparator readable; interrupt only when its enable bit is set.
// - wait interrupt source toggles at io clock while wait below reference.
// - half-supply interrupt source toggles at io clock while pin below threshold.
// - byte 0 write to converter control stores its fields; starts a conversion only while converter is on.
// - sampling starts one converter clock after the starting write completes.
// - end of conversion sets done flag; 8 msbs high register, 2 lsbs control.
// - result is unsigned integer of input over reference multiplied by 1024.
// - exactly one of 16 analog inputs routed by channel select while sampling, none otherwise.
// - total conversion lasts 4, 8, 16 or 32 us by sample time select.
// - write to converter control clears the done flag.
// - sample codes give 20/60/140/300 clocks sampling, total 20 clocks longer.
// - channels 0..7 first analog port, 8..15 second port.
// - reference 0 main, 1 internal, 2 first alternate, 3 second alternate.
module analog_section_adc_control
  import analog_section_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // wishbone slave
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [3:0]  adr_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [31:0] dat_i,
  output logic [31:0]      dat_o,
  output logic             ack_o,
  // system side
  input  wire cpu_mode_t   cpu_mode_i,
  input  wire logic        converter_clock_i,  // one-cycle tick per converter clock
  input  wire logic        io_clock_i,         // one-cycle tick per io clock
  // analog side
  input  wire logic        regulator_overload_i,
  input  wire logic        wait_below_ref_i,
  input  wire logic        half_supply_below_i,
  input  wire logic [9:0]  sar_code_i,         // quantised code from the analog core
  output power_t           power_o,
  output conv_req_t        conv_req_o,
  output logic [15:0]      channel_onehot_o,
  output logic [3:0]       reference_onehot_o,
  output logic             input_buffer_select_o,
  output logic             sampling_o,
  output logic             lock_special_output_o,
  output logic             wait_hysteresis_out_o,
  output logic             wait_irq_src_o,
  output logic             half_supply_irq_src_o
);

  ////////////////////////////////////////////////////////////////////////////
  // registers
  logic [7:0]  sys_ctrl_r;
  conv_req_t   conv_req_r;
  logic        input_buffer_select_r;
  logic        half_supply_irq_enable_r;
  logic        regulator_error_flag_r;
  logic        conversion_done_flag_r;
  logic [9:0]  result_r;
  logic        ack_r;
  logic [31:0] dat_r;
  logic        wait_irq_r;
  logic        hs_irq_r;
  conv_state_t state_r;
  conv_state_t state_nxt;
  logic [8:0]  cnt_r;
  logic [8:0]  cnt_nxt;

  ////////////////////////////////////////////////////////////////////////////
  // bus decode
  wire logic       bus_req     = cyc_i & stb_i & ~ack_r;
  wire logic       wr_byte0    = bus_req & we_i & sel_i[0];
  wire logic       hit_ctrl    = (adr_i == CONV_CTRL_OFS);
  wire logic       hit_high    = (adr_i == CONV_HIGH_OFS);
  wire logic       hit_sts     = (adr_i == ANALOG_STS_OFS);
  wire logic       hit_sys     = (adr_i == SYS_CTRL_OFS);
  wire logic       start_wr    = wr_byte0 & hit_ctrl;
  wire logic [7:0] wd          = dat_i[7:0];

  // control fields
  wire logic       analog_enable_bit   = sys_ctrl_r[ANA_EN_BIT];
  wire logic [2:0] pll_mode_field      = sys_ctrl_r[PLL_MODE_LSB +: 3];
  wire logic [1:0] lock_output_select  = sys_ctrl_r[LOCK_SEL_LSB +: 2];
  wire logic       pll_active          = (pll_mode_field != 3'h0);

  ////////////////////////////////////////////////////////////////////////////
  // power activation
  assign power_o.ref_gen_on     = (cpu_mode_i != MODE_SLOW) ? 1'b1
                                  : (analog_enable_bit | pll_active);
  assign power_o.regulator_on   = pll_active & (cpu_mode_i != MODE_RESET);
  assign power_o.comparators_on = analog_enable_bit & (cpu_mode_i != MODE_RESET);
  assign power_o.converter_on   = analog_enable_bit & (cpu_mode_i != MODE_RESET);

  // comparator outputs and lock pin
  assign wait_hysteresis_out_o = wait_below_ref_i & power_o.comparators_on;
  assign lock_special_output_o = (lock_output_select == LOCK_SEL_OVERLOAD)
                                 & regulator_overload_i;
  assign wait_irq_src_o        = wait_irq_r;
  assign half_supply_irq_src_o = hs_irq_r;

  // interrupt sources toggle on each io tick while the condition holds
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wait_irq_r <= 1'b0;
      hs_irq_r   <= 1'b0;
    end else begin
      if (io_clock_i && wait_hysteresis_out_o)
        wait_irq_r <= ~wait_irq_r;
      else if (!wait_hysteresis_out_o)
        wait_irq_r <= 1'b0;
      if (io_clock_i && half_supply_below_i && power_o.comparators_on
          && half_supply_irq_enable_r)
        hs_irq_r <= ~hs_irq_r;
      else if (!(half_supply_below_i && half_supply_irq_enable_r))
        hs_irq_r <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // multiplexer and reference decode
  genvar g;
  generate
    for (g = 0; g < 16; g++) begin : g_chan
      assign channel_onehot_o[g] = sampling_o
                                   & (conv_req_r.input_channel_select == 4'(g));
    end
    for (g = 0; g < 4; g++) begin : g_ref
      assign reference_onehot_o[g] = power_o.converter_on
                                     & (conv_req_r.reference_select == 2'(g));
    end
  endgenerate

  assign conv_req_o            = conv_req_r;
  assign input_buffer_select_o = input_buffer_select_r;
  assign sampling_o            = (state_r == ST_SAMPLE);

  ////////////////////////////////////////////////////////////////////////////
  // converter sequencer, counted in converter clock ticks
  wire logic [8:0] samp_len = SAMPLE_CLKS[conv_req_r.sample_time_select];
  wire logic       last     = converter_clock_i & (cnt_r == 9'd1);

  always_comb begin
    state_nxt = state_r;
    cnt_nxt   = cnt_r;
    case (state_r)
      ST_IDLE: begin
        cnt_nxt = 9'd1;
      end
      ST_DELAY: begin
        if (converter_clock_i) begin
          state_nxt = ST_SAMPLE;
          cnt_nxt   = samp_len;
        end
      end
      ST_SAMPLE: begin
        if (converter_clock_i)
          cnt_nxt = cnt_r - 9'd1;
        if (last) begin
          state_nxt = ST_CONV;
          cnt_nxt   = EXTRA_CLKS;
        end
      end
      ST_CONV: begin
        if (converter_clock_i)
          cnt_nxt = cnt_r - 9'd1;
        if (last)
          state_nxt = ST_IDLE;
      end
      default: state_nxt = ST_IDLE;
    endcase
    if (start_wr && power_o.converter_on) begin
      state_nxt = ST_DELAY;
      cnt_nxt   = 9'd1;
    end
    if (!power_o.converter_on)
      state_nxt = ST_IDLE;
  end

  wire logic conv_end = (state_r == ST_CONV) & last & ~start_wr;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_r <= ST_IDLE;
      cnt_r   <= 9'd0;
    end else begin
      state_r <= state_nxt;
      cnt_r   <= cnt_nxt;
    end
  end

  // result and done flag
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      conversion_done_flag_r <= 1'b0;
      result_r               <= 10'h000;
    end else if (start_wr) begin
      conversion_done_flag_r <= 1'b0;
    end else if (conv_end) begin
      conversion_done_flag_r <= 1'b1;
      result_r               <= sar_code_i;
    end else if (!power_o.converter_on) begin
      conversion_done_flag_r <= 1'b1; // unpowered converter reads ready
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // register writes
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sys_ctrl_r               <= SYS_CTRL_RST;
      conv_req_r               <= conv_req_t'(CONV_CTRL_RST);
      input_buffer_select_r    <= 1'b0;
      half_supply_irq_enable_r <= 1'b0;
    end else begin
      if (wr_byte0 && hit_sys)
        sys_ctrl_r <= wd;
      if (start_wr)
        conv_req_r <= conv_req_t'(wd);
      if (wr_byte0 && hit_high)
        input_buffer_select_r <= wd[0];
      if (wr_byte0 && hit_sts)
        half_supply_irq_enable_r <= wd[HS_IRQ_EN_BIT];
    end
  end

  // overload latch: set wins over write-one clear
  always_ff @(posedge clk_i) begin
    if (rst_i)
      regulator_error_flag_r <= 1'b0;
    else if (regulator_overload_i && power_o.regulator_on)
      regulator_error_flag_r <= 1'b1;
    else if (wr_byte0 && hit_sts && wd[REG_ERR_BIT])
      regulator_error_flag_r <= 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // read mux and ack
  wire logic [7:0] rd_ctrl = {conversion_done_flag_r, 5'h00, result_r[1:0]};
  wire logic [7:0] rd_high = result_r[9:2];
  wire logic [7:0] rd_sts  = {half_supply_irq_enable_r,
                              half_supply_below_i & power_o.comparators_on,
                              wait_hysteresis_out_o,
                              4'h0, regulator_error_flag_r};
  wire logic [7:0] rd_byte = hit_ctrl ? rd_ctrl :
                             hit_high ? rd_high :
                             hit_sts  ? rd_sts  :
                             hit_sys  ? sys_ctrl_r : 8'h00;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_r <= 1'b0;
      dat_r <= 32'h0000_0000;
    end else begin
      ack_r <= bus_req;
      if (bus_req && !we_i)
        dat_r <= {24'h00_0000, rd_byte};
    end
  end

  assign ack_o = ack_r;
  assign dat_o = dat_r;

  ////////////////////////////////////////////////////////////////////////////
  // assertions
  property p_done_clear;
    @(posedge clk_i) disable iff (rst_i)
      start_wr |=> !conversion_done_flag_r;
  endproperty
  a_done_clear: assert property (p_done_clear) else $error("done not cleared");

  property p_delay_then_sample;
    @(posedge clk_i) disable iff (rst_i)
      (state_r == ST_DELAY && converter_clock_i && !start_wr && power_o.converter_on)
        |=> sampling_o;
  endproperty
  a_delay_then_sample: assert property (p_delay_then_sample) else $error("no sample");

  property p_end_sets;
    @(posedge clk_i) disable iff (rst_i)
      conv_end |=> conversion_done_flag_r && result_r == $past(sar_code_i);
  endproperty
  a_end_sets: assert property (p_end_sets) else $error("result not stored");

  property p_hold;
    @(posedge clk_i) disable iff (rst_i)
      !conv_end |=> $stable(result_r);
  endproperty
  a_hold: assert property (p_hold) else $error("result moved");

  property p_reg;
    @(posedge clk_i) disable iff (rst_i)
      power_o.regulator_on == (pll_active && cpu_mode_i != MODE_RESET);
  endproperty
  a_reg: assert property (p_reg) else $error("regulator enable wrong");

  property p_ref;
    @(posedge clk_i) disable iff (rst_i)
      (cpu_mode_i != MODE_SLOW) |-> power_o.ref_gen_on;
  endproperty
  a_ref: assert property (p_ref) else $error("reference off");

  property p_err;
    @(posedge clk_i) disable iff (rst_i)
      (regulator_overload_i && power_o.regulator_on) |=> regulator_error_flag_r;
  endproperty
  a_err: assert property (p_err) else $error("overload not latched");

  property p_onehot;
    @(posedge clk_i) disable iff (rst_i)
      sampling_o |-> $onehot(channel_onehot_o);
  endproperty
  a_onehot: assert property (p_onehot) else $error("mux not one-hot");

  property p_wait_toggle;
    @(posedge clk_i) disable iff (rst_i)
      (io_clock_i && wait_hysteresis_out_o) |=> wait_irq_src_o != $past(wait_irq_src_o);
  endproperty
  a_wait_toggle: assert property (p_wait_toggle) else $error("wait irq stuck");

  property p_hs_gate;
    @(posedge clk_i) disable iff (rst_i)
      !half_supply_irq_enable_r |=> !half_supply_irq_src_o;
  endproperty
  a_hs_gate: assert property (p_hs_gate) else $error("hs irq ungated");

  // half-supply source must keep toggling while enabled and below threshold
  property p_hs_toggle;
    @(posedge clk_i) disable iff (rst_i)
      (io_clock_i && half_supply_below_i && power_o.comparators_on
       && half_supply_irq_enable_r)
        |=> half_supply_irq_src_o != $past(half_supply_irq_src_o);
  endproperty
  a_hs_toggle: assert property (p_hs_toggle) else $error("hs irq stuck");

  // reset cpu mode keeps comparators and converter unpowered
  property p_off_in_reset;
    @(posedge clk_i) disable iff (rst_i)
      (cpu_mode_i == MODE_RESET) |-> !power_o.comparators_on && !power_o.converter_on;
  endproperty
  a_off_in_reset: assert property (p_off_in_reset) else $error("analog on in reset");

  c_conv: cover property (@(posedge clk_i) disable iff (rst_i) conv_end);
  c_start: cover property (@(posedge clk_i) disable iff (rst_i) start_wr);
  c_err: cover property (@(posedge clk_i) disable iff (rst_i) regulator_error_flag_r);
  c_samp: cover property (@(posedge clk_i) disable iff (rst_i) $rose(sampling_o));

endmodule

//--- analog_far_side.sv
// partner model: analog core behind the input multiplexer and reference select
`timescale 1ns/100ps
module analog_far_side (
  input  wire logic        clk_i,
  input  wire logic [15:0] channel_onehot_i,
  input  wire logic [3:0]  reference_onehot_i,
  input  wire logic        sampling_i,
  output logic [9:0]       sar_code_o
);
  logic [9:0] held_r;
  ////////////////////////////////////////////////////////////////////////////////
  // channel k sits at 100 + 250*k mV; references 5000/2500/4096/3000 mV
  function automatic logic [9:0] quant(input logic [15:0] ch, input logic [3:0] rf);
    int mv [4] = '{5000, 2500, 4096, 3000};
    int v;
    int r;
    int c;
    v = 0;
    r = 1;
    for (int k = 0; k < 16; k++) if (ch[k]) v = 100 + k * 250;
    for (int k = 0; k < 4; k++) if (rf[k]) r = mv[k];
    c = v * 1024 / r;
    if (c > 1023) c = 1023;
    return c[9:0];
  endfunction
  // track the sampled level; while sampling the code is not yet valid
  always_ff @(posedge clk_i) begin
    if (sampling_i) held_r <= quant(channel_onehot_i, reference_onehot_i);
  end
  // the code is shown inverted while sampling so a too-early capture is seen
  assign sar_code_o = sampling_i ? ~held_r : held_r;
endmodule

//--- tb_top.sv
// testbench: drives wishbone, ticks and analog levels of the analog section control
`timescale 1ns/100ps
module tb_top;
  import analog_section_pkg::*;
  logic        clk_i, rst_i, cyc_i, stb_i, we_i, ovl, wait_lo, hs_lo;
  logic        cv_tick = 1'b0;
  logic        io_tick = 1'b0;
  logic        ack_o, buf_o, samp, lock_o, wait_hysteresis_out, wirq, hirq;
  logic [3:0]  adr, sel, rf_oh;
  logic [3:0]  tk = 4'h0;
  logic [31:0] wdat, dat_o, rd;
  logic [9:0]  sar;
  logic [15:0] ch_oh;
  cpu_mode_t   mode;
  power_t      pwr;
  conv_req_t   req;
  int          err_count, n_tests, a, b;
  int          slen = 0;
  ////////////////////////////////////////////////////////////////////////////////
  analog_section_adc_control dut_u (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
    .stb_i(stb_i), .we_i(we_i), .adr_i(adr), .sel_i(sel), .dat_i(wdat), .dat_o(dat_o),
    .ack_o(ack_o), .cpu_mode_i(mode), .converter_clock_i(cv_tick), .io_clock_i(io_tick),
    .regulator_overload_i(ovl), .wait_below_ref_i(wait_lo), .half_supply_below_i(hs_lo),
    .sar_code_i(sar), .power_o(pwr), .conv_req_o(req), .channel_onehot_o(ch_oh),
    .reference_onehot_o(rf_oh), .input_buffer_select_o(buf_o), .sampling_o(samp),
    .lock_special_output_o(lock_o), .wait_hysteresis_out_o(wait_hysteresis_out),
    .wait_irq_src_o(wirq), .half_supply_irq_src_o(hirq));
  analog_far_side far_u (.clk_i(clk_i), .channel_onehot_i(ch_oh),
    .reference_onehot_i(rf_oh), .sampling_i(samp), .sar_code_o(sar));
  ////////////////////////////////////////////////////////////////////////////////
  // clock, 10 MHz converter ticks, 5 MHz io ticks, sampling length counter
  initial begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end
  always @(posedge clk_i) begin
    tk <= tk + 4'h1;
    cv_tick <= (tk[1:0] == 2'h3);
    io_tick <= (tk[2:0] == 3'h7);
    slen <= (samp === 1'b1) ? slen + 1 : 0;
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic finish_test;
    $display("tests=%0d errors=%0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk_rng(input int got, input int lo, input int hi);
    n_tests++;
    if (got < lo || got > hi) begin
      err_count++;
      $display("ERROR t=%0t got=%h exp=%h..%h", $time, got, lo, hi);
    end
  endtask
  // one classic wishbone cycle; waits for ack, a hang is ended by the watchdog
  task automatic wb(input logic w, input logic [3:0] ad, input logic [31:0] d,
                    output logic [31:0] q);
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr <= ad;
    sel <= 4'hf;
    wdat <= d;
    do begin
      @(posedge clk_i);
    end while (ack_o !== 1'b1);
    q = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    we_i <= 1'b0;
  endtask
  // counts toggles of both interrupt sources over 80 cycles (10 io ticks)
  task automatic tog(output int ta, output int tb);
    logic pw;
    logic ph;
    ta = 0;
    tb = 0;
    pw = wirq;
    ph = hirq;
    repeat (80) begin
      @(posedge clk_i);
      if (wirq !== pw) ta++;
      if (hirq !== ph) tb++;
      pw = wirq;
      ph = hirq;
    end
  endtask
  function automatic int exp_code(input int ch, input int rf);
    int mv [4] = '{5000, 2500, 4096, 3000};
    int c;
    c = (100 + ch * 250) * 1024 / mv[rf];
    return (c > 1023) ? 1023 : c;
  endfunction
  // one conversion: start, mux checks, busy, durations, result
  task automatic conv(input logic [1:0] ts, input logic [1:0] rf, input logic [3:0] ch);
    int n;
    int ex;
    int tot;
    realtime t0;
    logic [31:0] lo;
    ex = exp_code(ch, rf);
    tot = (int'(SAMPLE_CLKS[ts]) + int'(EXTRA_CLKS)) * 4;
    wb(1'b1, CONV_CTRL_OFS, {24'h0, ts, rf, ch}, lo);
    t0 = $realtime;
    n = 0;
    while (samp !== 1'b1 && n < 12) begin
      @(posedge clk_i);
      n++;
    end
    chk_rng(n, 1, 6);
    chk({24'h0, req}, {24'h0, ts, rf, ch});
    chk({16'h0, ch_oh}, 32'h1 << ch);
    chk({28'h0, rf_oh}, 32'h1 << rf);
    wb(1'b0, CONV_CTRL_OFS, 32'h0, lo);
    chk(lo & 32'h80, 32'h0);
    n = 0;
    while (samp === 1'b1 && n < 1300) begin
      @(posedge clk_i);
      n++;
    end
    chk_rng(slen, tot - 81, tot - 79);
    do wb(1'b0, CONV_CTRL_OFS, 32'h0, lo); while (lo[7] !== 1'b1 && $realtime - t0 < 4e4);
    chk_rng(int'(($realtime - t0) / 25.0), tot - 2, tot + 8);
    chk(lo, 32'h80 | (ex & 3));
    wb(1'b0, CONV_HIGH_OFS, 32'h0, rd);
    chk(rd, ex >> 2);
    repeat (30) @(posedge clk_i);
    wb(1'b0, CONV_HIGH_OFS, 32'h0, rd);
    chk(rd, ex >> 2);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    static logic [3:0] ad [5] = '{CONV_CTRL_OFS, CONV_HIGH_OFS, ANALOG_STS_OFS, SYS_CTRL_OFS,
                                  4'h2};
    static logic [7:0] ev [5] = '{8'h80, 8'h00, 8'h00, 8'h00, 8'h00};
    static cpu_mode_t  pm [7] = '{MODE_RESET, MODE_RESET, MODE_FAST, MODE_FAST, MODE_SLOW,
                                  MODE_SLOW, MODE_SLOW};
    static logic [7:0] ps [7] = '{8'h00, 8'h01, 8'h00, 8'h03, 8'h00, 8'h01, 8'h02};
    static logic [3:0] pe [7] = '{4'h8, 4'h8, 4'h8, 4'hf, 4'h0, 4'hb, 4'hc};
    {cyc_i, stb_i, we_i, ovl, wait_lo, hs_lo} = 6'h00;
    {adr, sel, wdat} = 40'h0;
    err_count = 0;
    n_tests = 0;
    mode = MODE_RESET;
    rst_i = 1'b1;
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(1'b1, 4'h2, 32'hff, rd);
    for (int i = 0; i < 5; i++) begin
      wb(1'b0, ad[i], 32'h0, rd);
      chk(rd, {24'h0, ev[i]});
    end
    for (int i = 0; i < 7; i++) begin
      mode <= pm[i];
      wb(1'b1, SYS_CTRL_OFS, {24'h0, ps[i]}, rd);
      wb(1'b0, SYS_CTRL_OFS, 32'h0, rd);
      chk(rd, {24'h0, ps[i]});
      chk({28'h0, pwr}, {28'h0, pe[i]});
    end
    mode <= MODE_FAST;
    wb(1'b1, SYS_CTRL_OFS, 32'h13, rd); // pll mode nonzero keeps the regulator powered
    repeat (40) @(posedge clk_i);
    ovl <= 1'b1;
    repeat (3) @(posedge clk_i);
    chk({31'h0, lock_o}, 32'h1);
    ovl <= 1'b0;
    repeat (3) @(posedge clk_i);
    chk({31'h0, lock_o}, 32'h0);
    wb(1'b0, ANALOG_STS_OFS, 32'h0, rd);
    chk(rd, 32'h01);
    wb(1'b1, ANALOG_STS_OFS, 32'h01, rd);
    wb(1'b0, ANALOG_STS_OFS, 32'h0, rd);
    chk(rd, 32'h00);
    wait_lo <= 1'b1;
    repeat (3) @(posedge clk_i);
    chk({31'h0, wait_hysteresis_out}, 32'h1);
    wb(1'b0, ANALOG_STS_OFS, 32'h0, rd);
    chk(rd, 32'h20);
    tog(a, b);
    chk_rng(a, 9, 11);
    hs_lo <= 1'b1;
    wb(1'b0, ANALOG_STS_OFS, 32'h0, rd);
    chk(rd, 32'h60);
    tog(a, b);
    chk_rng(b, 0, 0);
    wb(1'b1, ANALOG_STS_OFS, 32'h80, rd);
    wb(1'b0, ANALOG_STS_OFS, 32'h0, rd);
    chk(rd, 32'he0);
    tog(a, b);
    chk_rng(b, 9, 11);
    {wait_lo, hs_lo} <= 2'b00;
    repeat (12) @(posedge clk_i);
    tog(a, b);
    chk_rng(a + b, 0, 0);
    wb(1'b1, CONV_HIGH_OFS, 32'h01, rd);
    chk({31'h0, buf_o}, 32'h1);
    repeat (40) @(posedge clk_i);
    for (int c = 0; c < 16; c++) conv(2'h0, c[1:0], c[3:0]);
    for (int t = 1; t < 4; t++) conv(t[1:0], t[1:0], 4'(t * 5));
    finish_test;
  end
  // watchdog
  initial begin
    repeat (20000) @(posedge clk_i);
    err_count++;
    finish_test;
  end
endmodule
